// ---- hw/pin_routing_pkg.sv ----
// package for the pin routing selector: register map, codes, state layout
// assumes a 32-bit axi4-lite slave, one clock, 5-bit selector registers and a 1-bit lock register
package pin_routing_pkg;
   localparam int N_IN = 9;
   localparam int N_OUT = 17;
   localparam int N_PIN = 18;
   localparam int SEL_W = 5;
   // byte address of the lock register, page numbers of the selector groups, response codes
   localparam logic [11:0] LOCK_OFFSET = 12'h000;
   localparam logic [5:0] IN_PAGE = 6'h01;
   localparam logic [4:0] OUT_PAGE = 5'h01;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // unlock keys and the locked flag position
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
   localparam int LOCKED_BIT = 0;
   // input codes: port a, port b upper half, port c
   localparam logic [4:0] IN_A_LAST = 5'h05;
   localparam logic [4:0] IN_B_FIRST = 5'h0c;
   localparam logic [4:0] IN_B_LAST = 5'h0f;
   localparam logic [4:0] IN_C_FIRST = 5'h10;
   localparam logic [4:0] IN_C_SMALL_LAST = 5'h15;
   localparam logic [4:0] IN_C_LAST = 5'h17;
   localparam logic [4:0] IN_SHIFT = 5'h06;
   // output source codes
   localparam logic [4:0] SRC_LATCH = 5'h00;
   localparam logic [4:0] SRC_CAPTURE_COMPARE1_OUTPUT = 5'h0c;
   localparam logic [4:0] SRC_CAPTURE_COMPARE2_OUTPUT = 5'h0d;
   localparam logic [4:0] SRC_SDA = 5'h11;
   localparam logic [4:0] SRC_SDO = 5'h12;
   localparam logic [4:0] SRC_CMP1 = 5'h16;
   localparam logic [4:0] SRC_CMP2 = 5'h17;
   localparam logic RESERVED_LEVEL = 1'b0;
   // input defaults after power-on, one per peripheral input (index 8 first)
   localparam logic [N_IN-1:0][SEL_W-1:0] IN_SEL_DEFAULT =
      {5'h13, 5'h11, 5'h10, 5'h13, 5'h15, 5'h04, 5'h05, 5'h02, 5'h02};
   typedef enum logic [1:0] {SEQ_IDLE = 2'b00, SEQ_KEY1 = 2'b01, SEQ_ARMED = 2'b11} seq_t;
   typedef struct packed {
      logic cmp2;
      logic cmp1;
      logic sdo;
      logic sda;
      logic sda_oe;
      logic capture_compare2_output;
      logic capture_compare1_output;
   } periph_out_t;
   typedef struct packed {
      logic [N_IN-1:0][SEL_W-1:0] in_sel;
      logic [N_OUT-1:0][SEL_W-1:0] out_sel;
      logic locked;
      logic cleared_once;
      logic sealed;
      seq_t seq;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [N_PIN-1:0] sync1;
      logic [N_PIN-1:0] sync2;
      logic [N_PIN-1:0] sync3;
      logic [N_PIN-1:0] level;
      logic [N_OUT-1:0] pin_out;
      logic [N_OUT-1:0] pin_oe;
      logic [N_IN-1:0] periph_in;
   } state_t;
   localparam state_t STATE_POR = '{in_sel: IN_SEL_DEFAULT, seq: SEQ_IDLE, default: '0};
endpackage

// ---- hw/pin_routing_select.sv ----
// pin routing selector: per-peripheral input selectors, per-pin source selectors, lock
// assumes axi4-lite master on aclk; pins are asynchronous; periph and latch are on aclk
`timescale 1ns/1ps
`default_nettype none
module pin_routing_select
   import pin_routing_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic device_reset_n,
   input wire logic one_shot_lock_fuse,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [N_PIN-1:0] pin_in,
   input wire logic [N_OUT-1:0] pin_output_latch,
   input wire logic [N_OUT-1:0] port_dir_out,
   input wire periph_out_t periph_out,
   output logic [N_OUT-1:0] pin_out,
   output logic [N_OUT-1:0] pin_oe,
   output logic [N_IN-1:0] periph_in,
   output logic [N_PIN-1:0] port_level
);
   state_t r;
   state_t n;
   logic wr_fire;
   logic rd_fire;
   logic w_lock;
   logic w_in;
   logic w_out;
   logic r_lock;
   logic r_in;
   logic r_out;
   logic [N_OUT-1:0] out_val;
   logic [N_OUT-1:0] oe_val;
   logic [N_IN-1:0] in_val;

   // one pin's level for an input code; reserved codes give zero
   function automatic logic in_src(input logic [4:0] c, input logic [N_PIN-1:0] lv);
      logic ok;
      logic [4:0] i;
      ok = (c <= IN_A_LAST) || (c >= IN_C_FIRST && c <= IN_C_SMALL_LAST);
      ok = ok || (LARGE_VARIANT && ((c >= IN_B_FIRST && c <= IN_B_LAST) ||
                                    (c > IN_C_SMALL_LAST && c <= IN_C_LAST)));
      i = (c <= IN_A_LAST) ? c : c - IN_SHIFT;
      return ok ? lv[i] : 1'b0;
   endfunction

   // pin drive for a source code
   function automatic logic out_src(input logic [4:0] c, input logic lat, input periph_out_t p);
      logic v;
      v = RESERVED_LEVEL;
      unique case (c)
         SRC_CMP2: v = p.cmp2;
         SRC_CMP1: v = p.cmp1;
         SRC_SDO: v = p.sdo;
         SRC_SDA: v = p.sda;
         SRC_CAPTURE_COMPARE2_OUTPUT: v = p.capture_compare2_output;
         SRC_CAPTURE_COMPARE1_OUTPUT: v = p.capture_compare1_output;
         SRC_LATCH: v = lat;
         default: v = RESERVED_LEVEL;
      endcase
      return v;
   endfunction

   // one source mux per routable pin
   for (genvar k = 0; k < N_OUT; k++) begin : g_out
      assign out_val[k] = out_src(r.out_sel[k], pin_output_latch[k], periph_out);
      assign oe_val[k] = (r.out_sel[k] == SRC_SDA) ? periph_out.sda_oe : port_dir_out[k];
   end

   // one input mux per peripheral input
   for (genvar j = 0; j < N_IN; j++) begin : g_in
      assign in_val[j] = in_src(r.in_sel[j], r.level);
   end

   // address decode; one write and one read in flight, both answered next cycle
   assign wr_fire = awvalid & wvalid & ~r.bvalid;
   assign rd_fire = arvalid & ~r.rvalid;
   assign w_lock = (awaddr == LOCK_OFFSET);
   assign w_in = (awaddr[11:6] == IN_PAGE) && (awaddr[5:2] < 4'(N_IN)) && (awaddr[1:0] == 2'h0);
   assign w_out = (awaddr[11:7] == OUT_PAGE) && (awaddr[6:2] < 5'(N_OUT)) && (awaddr[1:0] == 2'h0);
   assign r_lock = (araddr == LOCK_OFFSET);
   assign r_in = (araddr[11:6] == IN_PAGE) && (araddr[5:2] < 4'(N_IN)) && (araddr[1:0] == 2'h0);
   assign r_out = (araddr[11:7] == OUT_PAGE) && (araddr[6:2] < 5'(N_OUT)) && (araddr[1:0] == 2'h0);

   // next state
   always_comb begin
      n = r;
      n.sync1 = pin_in;
      n.sync2 = r.sync1;
      n.sync3 = r.sync2;
      // level moves only when the last two stages agree
      n.level = (~(r.sync2 ^ r.sync3) & r.sync3) | ((r.sync2 ^ r.sync3) & r.level);
      n.pin_out = out_val;
      n.pin_oe = oe_val;
      n.periph_in = in_val;
      if (r.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      if (r.rvalid && rready) begin
         n.rvalid = 1'b0;
      end
      // reads; unimplemented upper bits return zero
      if (rd_fire) begin
         n.rvalid = 1'b1;
         n.rresp = (r_lock || r_in || r_out) ? RESP_OKAY : RESP_SLVERR;
         n.rdata = '0;
         // a read breaks the key sequence
         n.seq = SEQ_IDLE;
         if (r_lock) begin
            n.rdata[LOCKED_BIT] = r.locked;
         end else if (r_in) begin
            n.rdata[SEL_W-1:0] = r.in_sel[araddr[5:2]];
         end else if (r_out) begin
            n.rdata[SEL_W-1:0] = r.out_sel[araddr[6:2]];
         end
      end
      // writes; a write in the same cycle as a read decides the key sequence
      if (wr_fire) begin
         n.bvalid = 1'b1;
         n.bresp = (w_lock || w_in || w_out) ? RESP_OKAY : RESP_SLVERR;
         n.seq = SEQ_IDLE;
         if (w_lock && wstrb[0]) begin
            if (r.seq == SEQ_ARMED) begin
               if (wdata[LOCKED_BIT]) begin
                  if (!(one_shot_lock_fuse && r.sealed)) begin
                     n.locked = 1'b1;
                     n.sealed = one_shot_lock_fuse;
                  end
               end else begin
                  if (!(one_shot_lock_fuse && (r.sealed || r.cleared_once))) begin
                     n.locked = 1'b0;
                     n.cleared_once = r.cleared_once | one_shot_lock_fuse;
                  end
               end
            end else if (wdata[7:0] == UNLOCK_KEY1) begin
               n.seq = SEQ_KEY1;
            end else if (r.seq == SEQ_KEY1 && wdata[7:0] == UNLOCK_KEY2) begin
               n.seq = SEQ_ARMED;
            end
         end else if (w_in && wstrb[0] && !r.locked) begin
            n.in_sel[awaddr[5:2]] = wdata[SEL_W-1:0];
         end else if (w_out && wstrb[0] && !r.locked) begin
            n.out_sel[awaddr[6:2]] = wdata[SEL_W-1:0];
         end
      end
      // warm resets clear lock state but keep selections, even against a write
      if (!device_reset_n) begin
         n.in_sel = r.in_sel;
         n.out_sel = r.out_sel;
         n.locked = 1'b0;
         n.cleared_once = 1'b0;
         n.sealed = 1'b0;
         n.seq = SEQ_IDLE;
         n.bvalid = 1'b0;
         n.rvalid = 1'b0;
      end
   end

   // power-on reset restores defaults; no sleep input reaches the state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= STATE_POR;
      end else begin
         r <= n;
      end
   end

   // ready signals are combinational, valid and data from flops
   assign awready = wr_fire;
   assign wready = wr_fire;
   assign arready = rd_fire;
   assign bvalid = r.bvalid;
   assign bresp = r.bresp;
   assign rvalid = r.rvalid;
   assign rresp = r.rresp;
   assign rdata = r.rdata;
   assign pin_out = r.pin_out;
   assign pin_oe = r.pin_oe;
   assign periph_in = r.periph_in;
   assign port_level = r.level;

   // checks on the registered state
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   property p_locked_hold;
      (r.locked && wr_fire && device_reset_n) |=> $stable(r.in_sel) && $stable(r.out_sel);
   endproperty
   a_locked_hold: assert property (p_locked_hold) else $error("selector changed while locked");

   property p_sealed;
      (r.sealed && device_reset_n) |=> r.sealed && r.locked;
   endproperty
   a_sealed: assert property (p_sealed) else $error("sealed lock was released");

   property p_one_shot_set;
      ($rose(r.locked) && one_shot_lock_fuse) |-> r.sealed;
   endproperty
   a_one_shot_set: assert property (p_one_shot_set) else $error("fuse set lock not sealed");

   property p_warm_keep;
      !device_reset_n |=> $stable(r.in_sel) && $stable(r.out_sel) && !r.locked;
   endproperty
   a_warm_keep: assert property (p_warm_keep) else $error("warm reset touched selections");

   property p_por;
      disable iff (1'b0) !aresetn |=> r.in_sel == IN_SEL_DEFAULT && r.out_sel == '0 && !r.locked;
   endproperty
   a_por: assert property (p_por) else $error("power-on defaults wrong");

   property p_no_key;
      (wr_fire && w_lock && r.seq != SEQ_ARMED && device_reset_n) |=> $stable(r.locked);
   endproperty
   a_no_key: assert property (p_no_key) else $error("lock moved without keys");

   property p_read_zero;
      r.rvalid |-> r.rdata[31:SEL_W] == '0;
   endproperty
   a_read_zero: assert property (p_read_zero) else $error("unimplemented bits nonzero");

   property p_lock_read;
      (rd_fire && r_lock) |=> r.rdata == {31'h0, $past(r.locked)};
   endproperty
   a_lock_read: assert property (p_lock_read) else $error("lock read wrong");

   property p_level;
      $stable(pin_in)[*5] |-> port_level == pin_in;
   endproperty
   a_level: assert property (p_level) else $error("port level does not follow pin");

   property p_latch_src;
      (r.out_sel[0] == SRC_LATCH) |=> pin_out[0] == $past(pin_output_latch[0]);
   endproperty
   a_latch_src: assert property (p_latch_src) else $error("latch not routed");

   property p_cmp2_src;
      (r.out_sel[1] == SRC_CMP2) |=> pin_out[1] == $past(periph_out.cmp2);
   endproperty
   a_cmp2_src: assert property (p_cmp2_src) else $error("comparator 2 not routed");

   property p_oe;
      (r.out_sel[2] != SRC_SDA) |=> pin_oe[2] == $past(port_dir_out[2]);
   endproperty
   a_oe: assert property (p_oe) else $error("enable not from direction");

   property p_write_ans;
      wr_fire |=> bvalid;
   endproperty
   a_write_ans: assert property (p_write_ans) else $error("write not answered");

   property p_read_ans;
      (rd_fire && device_reset_n) |=> rvalid;
   endproperty
   a_read_ans: assert property (p_read_ans) else $error("read not answered");

   // selectors move only on an accepted write; sleep has no path into them
   property p_sel_write_only;
      !wr_fire |=> $stable(r.in_sel) && $stable(r.out_sel);
   endproperty
   a_sel_write_only: assert property (p_sel_write_only) else $error("selector moved");

   property p_key_arm;
      (wr_fire && w_lock && wstrb[0] && r.seq == SEQ_KEY1 && wdata[7:0] == UNLOCK_KEY2 &&
       device_reset_n) |=> r.seq == SEQ_ARMED;
   endproperty
   a_key_arm: assert property (p_key_arm) else $error("key pair did not arm");

   property p_read_breaks;
      (rd_fire && !wr_fire) |=> r.seq == SEQ_IDLE;
   endproperty
   a_read_breaks: assert property (p_read_breaks) else $error("read kept the key sequence");

   property p_sda_oe;
      (r.out_sel[0] == SRC_SDA) |=> pin_oe[0] == $past(periph_out.sda_oe);
   endproperty
   a_sda_oe: assert property (p_sda_oe) else $error("i2c data enable not used");

   property p_reserved_src;
      (r.out_sel[3] != SRC_LATCH && r.out_sel[3] < SRC_CAPTURE_COMPARE1_OUTPUT) |=>
         pin_out[3] == RESERVED_LEVEL;
   endproperty
   a_reserved_src: assert property (p_reserved_src) else $error("reserved code not constant");

   property p_in_route;
      (r.in_sel[0] <= IN_A_LAST) |=> periph_in[0] == $past(r.level[r.in_sel[0]]);
   endproperty
   a_in_route: assert property (p_in_route) else $error("port a input not routed");

   property p_in_reserved;
      (r.in_sel[6] > IN_A_LAST && r.in_sel[6] < IN_B_FIRST) |=> !periph_in[6];
   endproperty
   a_in_reserved: assert property (p_in_reserved) else $error("reserved input code not zero");

   c_lock_set: cover property ($rose(r.locked));
   c_unlock: cover property ($fell(r.locked));
   c_sealed: cover property ($rose(r.sealed));
   c_bad_addr: cover property (bvalid && bresp == RESP_SLVERR);
   c_key_armed: cover property (r.seq == SEQ_ARMED);
endmodule
`default_nettype wire

// ---- verification/pin_routing_far_side.sv ----
// far side model: peripheral outputs, port latches, direction bits and pins
// assumes the bench sets pin levels and the flip control just after a clock edge
`timescale 1ns/1ps
`default_nettype none
module pin_routing_far_side
   import pin_routing_pkg::*;
(
   input wire logic flip,
   input wire logic [N_PIN-1:0] pins,
   output var periph_out_t periph_out,
   output logic [N_OUT-1:0] pin_output_latch,
   output logic [N_OUT-1:0] port_dir_out,
   output logic [N_PIN-1:0] pin_in
);
   // pin levels reach the block as driven
   assign pin_in = pins;
   // latch and direction patterns swap so each pin sees both levels
   assign pin_output_latch = flip ? 17'h0a5a5 : 17'h15a5a;
   assign port_dir_out = flip ? 17'h1c3c3 : 17'h03c3c;
   // outputs alternate; sda enable runs against pin 0's direction bit
   assign periph_out = flip ? periph_out_t'(7'h51) : periph_out_t'(7'h2e);
endmodule
`default_nettype wire

// ---- verification/tb_top.sv ----
// bench for the pin routing selector: register access, routing, lock and resets
// assumes the far-side model drives peripherals, latches and pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pin_routing_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, device_reset_n = 1'b1, one_shot_lock_fuse = 1'b0;
   logic flip = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic [N_PIN-1:0] pins = '0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   periph_out_t po;
   logic [N_OUT-1:0] lat, dir, pin_out, pin_oe;
   logic [N_IN-1:0] periph_in;
   logic [N_PIN-1:0] pin_in, port_level;
   int fails = 0, num_checks = 0;

   // free-running core clock, 40 ns period
   initial begin
      forever #20 aclk = ~aclk;
   end

   pin_routing_far_side far (.flip(flip), .pins(pins), .periph_out(po),
      .pin_output_latch(lat), .port_dir_out(dir), .pin_in(pin_in));

   pin_routing_select dut (.aclk(aclk), .aresetn(aresetn), .device_reset_n(device_reset_n),
      .one_shot_lock_fuse(one_shot_lock_fuse), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .pin_in(pin_in), .pin_output_latch(lat), .port_dir_out(dir), .periph_out(po),
      .pin_out(pin_out), .pin_oe(pin_oe), .periph_in(periph_in), .port_level(port_level));

   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, x, g);
      end
   endtask

   // address and data go out together; bready waits for the answer
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] x);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", {30'h0, x}, {30'h0, bresp});
      @(posedge aclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [1:0] xr);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", x, rdata);
      chk("rresp", {30'h0, xr}, {30'h0, rresp});
      @(posedge aclk);
   endtask

   // key pair then the lock write
   task automatic lk(input logic [31:0] d);
      wr(LOCK_OFFSET, 32'h55, RESP_OKAY);
      wr(LOCK_OFFSET, 32'haa, RESP_OKAY);
      wr(LOCK_OFFSET, d, RESP_OKAY);
   endtask

   // one-cycle pulse of the power-on or the warm reset
   task automatic rst(input bit por);
      if (por) begin
         aresetn <= 1'b0;
      end else begin
         device_reset_n <= 1'b0;
      end
      @(posedge aclk);
      aresetn <= 1'b1;
      device_reset_n <= 1'b1;
      @(posedge aclk);
   endtask

   function automatic logic [11:0] ia(int i);
      return 12'h040 + 12'(4 * i);
   endfunction

   function automatic logic [11:0] oa(int i);
      return 12'h080 + 12'(4 * i);
   endfunction

   // port a 0-5, port b 4-7 at 0c-0f, port c 0-7 at 10-17; -1 for reserved codes
   function automatic int pin_of(logic [4:0] c);
      if (c <= 5'h05) return int'(c);
      if (c >= 5'h0c && c <= 5'h17) return int'(c) - 6;
      return -1;
   endfunction

   // expected {enable, level} of a pin for a source code
   function automatic logic [1:0] src_of(logic [4:0] c, int j);
      logic v;
      case (c)
         5'h00: v = lat[j];
         5'h17: v = po.cmp2;
         5'h16: v = po.cmp1;
         5'h12: v = po.sdo;
         5'h11: v = po.sda;
         5'h0d: v = po.capture_compare2_output;
         5'h0c: v = po.capture_compare1_output;
         default: v = RESERVED_LEVEL;
      endcase
      return {(c == 5'h11) ? po.sda_oe : dir[j], v};
   endfunction

   task automatic end_sim;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // watchdog: the sequence needs about 1100 cycles
   initial begin
      #1000000;
      fails++;
      end_sim();
   end

   initial begin
      int k;
      logic [4:0] c;
      logic [1:0] e;
      logic [N_PIN-1:0] oh;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(LOCK_OFFSET, 32'h0, RESP_OKAY);
      for (int i = 0; i < N_IN; i++) rd(ia(i), {27'h0, IN_SEL_DEFAULT[i]}, RESP_OKAY);
      for (int i = 0; i < N_OUT; i++) rd(oa(i), 32'h0, RESP_OKAY);
      rd(ia(N_IN), 32'h0, RESP_SLVERR);
      wr(oa(N_OUT), 32'h1, RESP_SLVERR);
      wr(ia(1), 32'hff, RESP_OKAY);
      wstrb <= 4'h0;
      wr(ia(1), 32'h03, RESP_OKAY);
      wstrb <= 4'hf;
      rd(ia(1), 32'h1f, RESP_OKAY);
      // every input code on a rotating selector, both pin polarities
      for (int n = 0; n < 32; n++) begin
         c = 5'(n);
         k = pin_of(c);
         oh = (k < 0) ? '0 : N_PIN'(1) << k;
         wr(ia(n % N_IN), {27'h0, c}, RESP_OKAY);
         for (int p = 0; p < 2; p++) begin
            pins <= (p == 1) ? oh : ~oh;
            repeat (8) @(posedge aclk);
            chk("periph_in", (k >= 0) ? p : 0, periph_in[n % N_IN]);
            chk("port_level", pins, port_level);
         end
      end
      // every source code on a rotating pin
      for (int n = 0; n < 32; n++) begin
         c = 5'(n);
         wr(oa(n % N_OUT), {27'h0, c}, RESP_OKAY);
         for (int p = 0; p < 2; p++) begin
            flip <= p[0];
            repeat (3) @(posedge aclk);
            e = src_of(c, n % N_OUT);
            chk("pin_out", e[0], pin_out[n % N_OUT]);
            chk("pin_oe", e[1], pin_oe[n % N_OUT]);
         end
      end
      // a read between the keys restarts detection
      wr(LOCK_OFFSET, 32'h55, RESP_OKAY);
      rd(LOCK_OFFSET, 32'h0, RESP_OKAY);
      wr(LOCK_OFFSET, 32'haa, RESP_OKAY);
      wr(LOCK_OFFSET, 32'h1, RESP_OKAY);
      rd(LOCK_OFFSET, 32'h0, RESP_OKAY);
      lk(32'hff);
      rd(LOCK_OFFSET, 32'h1, RESP_OKAY);
      wr(ia(2), 32'h03, RESP_OKAY);
      rd(ia(2), 32'h1d, RESP_OKAY);
      lk(32'h0);
      wr(ia(2), 32'h03, RESP_OKAY);
      rd(ia(2), 32'h03, RESP_OKAY);
      // one-shot lock after a warm reset
      one_shot_lock_fuse <= 1'b1;
      rst(1'b0);
      rd(ia(2), 32'h03, RESP_OKAY);
      rd(oa(14), 32'h1f, RESP_OKAY);
      lk(32'h0);
      lk(32'h1);
      rd(LOCK_OFFSET, 32'h1, RESP_OKAY);
      lk(32'h0);
      rd(LOCK_OFFSET, 32'h1, RESP_OKAY);
      wr(ia(2), 32'h07, RESP_OKAY);
      rd(ia(2), 32'h03, RESP_OKAY);
      rst(1'b0);
      rd(LOCK_OFFSET, 32'h0, RESP_OKAY);
      rst(1'b1);
      rd(ia(2), {27'h0, IN_SEL_DEFAULT[2]}, RESP_OKAY);
      rd(oa(4), 32'h0, RESP_OKAY);
      end_sim();
   end
endmodule
`default_nettype wire
